// ==== tb/acds_audio_src.sv ====
// Audio serial source model: master, bit and frame clocks for the clock detector
`default_nettype none
module acds_audio_src
(
	input  wire logic run,      // Bit and frame clocks run while high
	input  wire logic mclk_on,  // Master clock runs while high
	input  var  int   nbits,    // Bit clocks per frame
	input  var  int   low_bits, // Bit clocks with the frame clock low
	output logic      mclk_pin, // Master clock, 400 ns period
	output logic      sclk_pin, // Bit clock, 800 ns period
	output logic      lrclk_pin // Frame clock
);
	timeunit 1ns;
	timeprecision 1ns;
	int n;
	int lo;
	////////////////////////////////////////
	// Master clock; its odd phase keeps its edges off the sampling clock's edges
	initial
	begin
		mclk_pin = 1'b0;
		#37;
		forever
		begin
			#200;
			mclk_pin = mclk_on ? ~mclk_pin : 1'b0;
		end
	end
	// Frames start only whole; between frames both lines rest low, as a missing source would
	initial
	begin
		sclk_pin  = 1'b0;
		lrclk_pin = 1'b0;
		#13;
		forever
		begin
			n  = nbits;
			lo = low_bits;
			if (!run)
			begin
				sclk_pin  = 1'b0;
				lrclk_pin = 1'b0;
				#800;
			end
			else
				for (int i = 0; i < n; i++)
				begin
					sclk_pin  = 1'b0;
					lrclk_pin = (i >= lo);
					#400;
					sclk_pin  = 1'b1;
					#400;
				end
		end
	end
endmodule // acds_audio_src
`default_nettype wire

// ==== tb/acds_top_test.sv ====
// Testbench of the clock detector status block: APB register checks against a clock source model
`default_nettype none
module acds_top_test
	import acds_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] STAT_A = {STAT_IDX, 2'b00};
	localparam logic [11:0] CTRL_A = {CTRL_IDX, 2'b00};
	localparam logic [11:0] IST_A  = {IRQ_STAT_IDX, 2'b00};
	localparam logic [11:0] IMSK_A = {IRQ_MASK_IDX, 2'b00};
	localparam int          SCLK_CYC = 800 / CLK_PERIOD_NS;
	typedef struct {string name; logic [31:0] exp; logic [31:0] msk; logic err;} acds_note_t;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0001_754E;
	logic        pready, pslverr, pll_enable, irq, mclk_pin, sclk_pin, lrclk_pin;
	logic        pll_locked = 1'b0, run = 1'b0, mclk_on = 1'b0, pe = 1'b0, ign = 1'b0, b7 = 1'b0;
	int          nbits = 64, low_bits = 32, mismatches = 0, total_checks = 0, cycles = 0;
	acds_note_t  notes[$];
	acds_note_t  note;
	int          t_nb[9] = '{64, 64, 64, 48, 24, 32, 300, 64, 64};
	int          t_lo[9] = '{32, 5, 6, 24, 12, 16, 150, 32, 32};
	logic [8:0]  t_rn = 9'h0FF, t_mo = 9'h17F, t_pe = 9'h1DF;
	////////////////////////////////////////
	always #50 pclk = ~pclk;
	acds_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mclk_pin(mclk_pin), .sclk_pin(sclk_pin), .lrclk_pin(lrclk_pin), .pll_locked(pll_locked),
		.pll_enable(pll_enable), .irq(irq));
	acds_audio_src i_src (.run(run), .mclk_on(mclk_on), .nbits(nbits), .low_bits(low_bits),
		.mclk_pin(mclk_pin), .sclk_pin(sclk_pin), .lrclk_pin(lrclk_pin));
	////////////////////////////////////////
	// Helpers: random source, comparison, verdict
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Expected status from the source setup; stale measurements are masked by the caller
	function automatic logic [31:0] exp_stat();
		int   r;
		logic rok;
		logic mci;
		r   = mclk_on ? 2 * nbits : 0;
		rok = run && nbits * SCLK_CYC >= PER_MIN_CYC && nbits * SCLK_CYC <= PER_MAX_CYC;
		mci = !rok || !(r inside {32, 48, 64, 128, 192, 256, 384, 512, 768, 1024, 1152, 1536, 2048, 3072})
			|| low_bits <= LOW_MIN_SCLKS;
		return {24'h0, b7, !mclk_on, !(pe && pll_locked), !run, !rok || mci || (!pe && r < AUTO_MIN_RATIO),
			mci, !rok || nbits < BCLK_RATIO_MIN || nbits > BCLK_RATIO_MAX, !rok && !ign};
	endfunction
	////////////////////////////////////////
	// APB master: the note is queued first, the monitor checks it when the access completes
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input string nm,
		input logic [31:0] e, input logic [31:0] m, input logic err);
		notes.push_back('{nm, e, m, err});
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
		apb(1'b1, a, d, "write", 32'h0, 32'h0, err);
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF, input logic err = 1'b0);
		apb(1'b0, a, 32'h0, nm, e, m, err);
	endtask
	task automatic stat(input logic [31:0] m = 32'hFFFF_FFFF);
		rd("status", STAT_A, exp_stat(), m);
	endtask
	// Control write; the wait covers the lock synchroniser
	task automatic ctl(input logic p, input logic g);
		wr(CTRL_A, {30'h0, g, p});
		pe  = p;
		ign = g;
		repeat (8) @(posedge pclk);
		chk("pll_enable", {31'h0, p}, {31'h0, pll_enable});
	endtask
	// Source change; waits out the old frame, three new frames and the missing limits
	task automatic cfg(input int nb, input int lo, input logic rn, input logic mo);
		int w;
		w = SCLK_CYC * (nbits + 3 * nb) + PER_MAX_CYC + MISS_CYC;
		@(posedge pclk);
		nbits    <= nb;
		low_bits <= lo;
		run      <= rn;
		mclk_on  <= mo;
		repeat (w) @(posedge pclk);
	endtask
	////////////////////////////////////////
	// Monitor of completed transfers
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0)
		begin
			note = notes.pop_front();
			chk({note.name, " data"}, note.exp & note.msk, prdata & note.msk);
			chk({note.name, " error"}, {31'h0, note.err}, {31'h0, pslverr});
		end
	end
	// Hang guard, well above the expected run of some 60000 cycles
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	////////////////////////////////////////
	// Main sequence
	initial
	begin
		logic [31:0] d;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		stat();
		rd("control", CTRL_A, 32'h0);
		rd("irq mask", IMSK_A, 32'h0);
		rd("irq status", IST_A, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		rd("unmapped", 12'h000, 32'h0, 32'hFFFF_FFFF, 1'b1);
		wr(12'h004, xs(), 1'b1);
		for (int k = 0; k < 3; k++)
		begin
			d = xs();
			wr(STAT_A, d);
			b7 = d[7];
			stat();
		end
		ctl(1'b1, 1'b0);
		pll_locked <= 1'b1;
		repeat (8) @(posedge pclk);
		stat();
		pll_locked <= 1'b0;
		repeat (8) @(posedge pclk);
		stat();
		pll_locked <= 1'b1;
		ctl(1'b0, 1'b0);
		stat();
		for (int i = 0; i < 9; i++)
		begin
			ctl(t_pe[i], 1'b0);
			cfg(t_nb[i], t_lo[i], t_rn[i], t_mo[i]);
			stat(t_rn[i] ? 32'hFFFF_FFFF : 32'hFFFF_FFF0);
			if (t_rn[i] && (exp_stat() & 32'h1) != 32'h0)
			begin
				ctl(pe, 1'b1);
				stat();
				rd("control", CTRL_A, {30'h0, ign, pe});
			end
		end
		// Interrupt raised by a master clock loss, masked, unmasked and cleared
		cfg(64, 32, 1'b1, 1'b1);
		wr(IST_A, 32'h7F);
		rd("irq status", IST_A, 32'h0, 32'h7F);
		wr(IMSK_A, 32'h41);
		rd("irq mask", IMSK_A, 32'h41);
		chk("irq", 32'h0, {31'h0, irq});
		cfg(64, 32, 1'b1, 1'b0);
		rd("irq status", IST_A, 32'h40, 32'h41);
		chk("irq", 32'h1, {31'h0, irq});
		wr(IMSK_A, 32'h0);
		repeat (3) @(posedge pclk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(IMSK_A, 32'h40);
		repeat (3) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(IST_A, 32'h7F);
		repeat (3) @(posedge pclk);
		chk("irq", 32'h0, {31'h0, irq});
		// Random frame lengths and low periods around the boundary
		for (int k = 0; k < 2; k++)
		begin
			cfg(32 + int'(xs() % 200), 4 + int'(xs() % 4), 1'b1, 1'b1);
			stat();
		end
		// Mid-run reset: reserved bit, control and pll enable return to zero
		wr(STAT_A, 32'h80);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		b7 = 1'b0;
		pe = 1'b0;
		rd("status reserved", STAT_A, 32'h0, 32'h80);
		rd("control", CTRL_A, 32'h0);
		chk("pll_enable", 32'h0, {31'h0, pll_enable});
		end_of_test();
	end
endmodule // acds_top_test
`default_nettype wire

// ==== verilog/acds_pkg.sv ====
// Package: constants, register map and helpers of the audio clock detector status block
`default_nettype none
package acds_pkg;
	// Clock and timing
	localparam int          CLK_HZ         = 10_000_000;
	localparam int          MISS_TIME_NS   = 20_000;
	localparam int          CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
	localparam int          MISS_CYC       = MISS_TIME_NS / CLK_PERIOD_NS;
	localparam int          FS_MIN_HZ      = 8_000;
	localparam int          FS_MAX_HZ      = 384_000;
	localparam int          PER_MIN_CYC    = CLK_HZ / FS_MAX_HZ;
	localparam int          PER_MAX_CYC    = (CLK_HZ + FS_MIN_HZ - 1) / FS_MIN_HZ;
	// Detector limits
	localparam logic [8:0]  BCLK_RATIO_MIN = 9'h020;
	localparam logic [8:0]  BCLK_RATIO_MAX = 9'h100;
	localparam logic [8:0]  LOW_MIN_SCLKS  = 9'h005;
	localparam logic [11:0] AUTO_MIN_RATIO = 12'h080;
	// Register indices; byte address is four times the index
	localparam logic [9:0]  STAT_IDX       = 10'h05E;
	localparam logic [9:0]  CTRL_IDX       = 10'h060;
	localparam logic [9:0]  IRQ_STAT_IDX   = 10'h061;
	localparam logic [9:0]  IRQ_MASK_IDX   = 10'h062;
	// Status field positions
	localparam int          FL_SRI         = 0;
	localparam int          FL_BCI         = 1;
	localparam int          FL_MCI         = 2;
	localparam int          FL_AUTO        = 3;
	localparam int          FL_SER         = 4;
	localparam int          FL_PLL         = 5;
	localparam int          FL_MCM         = 6;
	localparam int          FL_RSV         = 7;
	// Control field positions and reset values
	localparam int          CTRL_PLL_EN    = 0;
	localparam int          CTRL_IGNORE    = 1;
	localparam logic [1:0]  CTRL_RESET     = 2'h0;
	localparam logic [6:0]  FLAGS_RESET    = 7'h7F;
	localparam logic [6:0]  MASK_RESET     = 7'h00;

	// Master clock ratios that the detector accepts
	function automatic logic acds_ratio_ok(input logic [11:0] n);
		case (n)
			12'h020, 12'h030, 12'h040, 12'h080, 12'h0C0, 12'h100, 12'h180,
			12'h200, 12'h300, 12'h400, 12'h480, 12'h600, 12'h800, 12'hC00: acds_ratio_ok = 1'b1;
			default: acds_ratio_ok = 1'b0;
		endcase
	endfunction
endpackage : acds_pkg
`default_nettype wire

// ==== verilog/acds_sync_edge.sv ====
// Two-flop synchroniser for a pin, with a rising-edge pulse taken after the second flop
`default_nettype none
module acds_sync_edge
	import acds_pkg::*;
(
	input  wire logic pclk,    // System clock
	input  wire logic presetn, // Asynchronous reset, active low
	input  wire logic d,       // Pin from another domain
	output logic      q,       // Synchronised level
	output logic      rise     // One-cycle pulse on a rising edge
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// Only the second flop reads the first; edge logic looks at later stages
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= d;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	// Outputs
	assign q    = sync_reg;
	assign rise = sync_reg & ~last_reg;
endmodule // acds_sync_edge
`default_nettype wire

// ==== verilog/acds_top.sv ====
// Audio clock detector status: clock monitors, live status register, interrupts, APB slave
//
// Overview of operation
// R1: Status bit 6 reads 1 while the master clock is missing or halted and 0 while it runs.
// R2: Status bit 5 reads 1 while the PLL is unlocked or disabled and 0 while it is enabled and locked.
// R3: Status bit 4 reads 1 only while both frame and bit clocks are missing and held low.
// R4: Status bit 3 reads 1 when sample rate and master clock ratio cannot be used for automatic setup.
// R5: Status bit 2 reads 1 whenever the master clock ratio cannot be detected as a valid ratio.
// R6: Status bit 2 also reads 1 whenever the frame clock low period is five bit clocks or fewer.
// R7: Status bit 1 reads 1 unless the bit clock ratio is stable and within 32 to 256 per frame.
// R8: Status bit 0 reads 1 while no valid sampling rate is detected and 0 while one is.
// R9: Status bit 0 is cleared and no longer reported while the error-ignore control is set.
// R10: Status bits are live and ignore writes; the top reserved bit stores its written value, reset zero.
`default_nettype none
module acds_top
	import acds_pkg::*;
(
	input  wire logic        pclk,           // APB clock, 10 MHz
	input  wire logic        presetn,        // Asynchronous reset, active low
	input  wire logic [11:0] paddr,          // APB byte address
	input  wire logic        psel,           // APB select
	input  wire logic        penable,        // APB enable
	input  wire logic        pwrite,         // APB write
	input  wire logic [31:0] pwdata,         // APB write data
	output logic      [31:0] prdata,         // APB read data
	output logic             pready,         // APB ready
	output logic             pslverr,        // APB error, unmapped address
	input  wire logic        mclk_pin,       // Master clock from the audio source
	input  wire logic        sclk_pin,       // Bit clock from the audio source
	input  wire logic        lrclk_pin,      // Frame clock from the audio source
	input  wire logic        pll_locked,     // PLL lock indication, asynchronous
	output logic             pll_enable,     // PLL enable, from control register
	output logic             irq             // Level interrupt, active high
);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and activity watchdogs
	logic mclk_s, mclk_rise, sclk_s, sclk_rise, lrclk_s, lrclk_rise, lock_s;
	logic mclk_miss, sclk_miss, lrclk_miss;

	// Every pin crosses into pclk through two flops; edges are found after the second
	acds_sync_edge u_sync_mclk
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d       (mclk_pin),
		.q       (mclk_s),
		.rise    (mclk_rise)
	);
	acds_sync_edge u_sync_sclk
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d       (sclk_pin),
		.q       (sclk_s),
		.rise    (sclk_rise)
	);
	acds_sync_edge u_sync_lrclk
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d       (lrclk_pin),
		.q       (lrclk_s),
		.rise    (lrclk_rise)
	);
	acds_sync_edge u_sync_lock
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pll_locked),
		.q       (lock_s),
		.rise    ()
	);

	acds_watchdog #(.LIMIT(MISS_CYC)) u_wd_mclk
	(
		.pclk    (pclk),
		.presetn (presetn),
		.kick    (mclk_rise),
		.missing (mclk_miss)
	);
	acds_watchdog #(.LIMIT(MISS_CYC)) u_wd_sclk
	(
		.pclk    (pclk),
		.presetn (presetn),
		.kick    (sclk_rise),
		.missing (sclk_miss)
	);
	// Frame clock watchdog runs longer: a slow frame has long half periods
	acds_watchdog #(.LIMIT(PER_MAX_CYC)) u_wd_lrclk
	(
		.pclk    (pclk),
		.presetn (presetn),
		.kick    (lrclk_rise),
		.missing (lrclk_miss)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Per-frame measurement counters, restarted on every frame clock rise
	logic [11:0] mclk_cnt_reg, mclk_lat_reg;
	logic [8:0]  sclk_cnt_reg, sclk_lat_reg, sclk_prev_reg;
	logic [8:0]  low_cnt_reg, low_lat_reg;
	logic [15:0] per_cnt_reg, per_lat_reg;
	logic [1:0]  frames_reg;

	wire mclk_cnt_sat = &mclk_cnt_reg;
	wire sclk_cnt_sat = &sclk_cnt_reg;
	wire low_cnt_sat  = &low_cnt_reg;
	wire per_cnt_sat  = &per_cnt_reg;

	// Counters saturate so an overlong frame reads as out of range, not wrapped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mclk_cnt_reg <= 12'h000;
			sclk_cnt_reg <= 9'h000;
			low_cnt_reg  <= 9'h000;
			per_cnt_reg  <= 16'h0000;
		end
		else if (lrclk_rise)
		begin
			mclk_cnt_reg <= {11'h000, mclk_rise};
			sclk_cnt_reg <= {8'h00, sclk_rise};
			low_cnt_reg  <= 9'h000;
			per_cnt_reg  <= 16'h0001;
		end
		else
		begin
			mclk_cnt_reg <= mclk_cnt_reg + {11'h000, mclk_rise & ~mclk_cnt_sat};
			sclk_cnt_reg <= sclk_cnt_reg + {8'h00, sclk_rise & ~sclk_cnt_sat};
			low_cnt_reg  <= low_cnt_reg + {8'h00, sclk_rise & ~lrclk_s & ~low_cnt_sat};
			per_cnt_reg  <= per_cnt_reg + {15'h0000, ~per_cnt_sat};
		end
	end

	// Latch the finished frame; two frames are needed before a result counts
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mclk_lat_reg  <= 12'h000;
			sclk_lat_reg  <= 9'h000;
			sclk_prev_reg <= 9'h000;
			low_lat_reg   <= 9'h000;
			per_lat_reg   <= 16'h0000;
			frames_reg    <= 2'h0;
		end
		else if (lrclk_miss)
			frames_reg <= 2'h0;
		else if (lrclk_rise)
		begin
			mclk_lat_reg  <= mclk_cnt_reg;
			sclk_prev_reg <= sclk_lat_reg;
			sclk_lat_reg  <= sclk_cnt_reg;
			low_lat_reg   <= low_cnt_reg;
			per_lat_reg   <= per_cnt_reg;
			frames_reg    <= frames_reg + {1'b0, ~frames_reg[1]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register
	logic [1:0] ctrl_reg;
	wire        ctrl_pll_en = ctrl_reg[CTRL_PLL_EN];
	wire        ctrl_ignore = ctrl_reg[CTRL_IGNORE];

	////////////////////////////////////////////////////////////////////////////////
	// Live detector conditions
	wire frame_ok   = frames_reg[1] & ~lrclk_miss;
	wire ratio_ok   = acds_ratio_ok(mclk_lat_reg);
	wire short_low  = low_lat_reg <= LOW_MIN_SCLKS;
	wire bclk_range = (sclk_lat_reg >= BCLK_RATIO_MIN) && (sclk_lat_reg <= BCLK_RATIO_MAX);
	wire bclk_stab  = sclk_lat_reg == sclk_prev_reg;
	wire rate_ok    = frame_ok && (per_lat_reg >= 16'(PER_MIN_CYC)) && (per_lat_reg <= 16'(PER_MAX_CYC));
	wire low_ratio  = ~ctrl_pll_en & (mclk_lat_reg < AUTO_MIN_RATIO);

	wire mcm_w  = mclk_miss;                                            // R1
	wire pll_w  = ~ctrl_pll_en | ~lock_s;                               // R2
	wire ser_w  = sclk_miss & lrclk_miss & ~sclk_s & ~lrclk_s;          // R3
	wire mci_w  = mclk_miss | ~frame_ok | ~ratio_ok                     // R5
	            | (frame_ok & short_low);                               // R6
	wire bci_w  = ~frame_ok | ~bclk_stab | ~bclk_range;                 // R7
	wire sri_w  = ~rate_ok & ~ctrl_ignore;                              // R8 R9
	wire auto_w = ~rate_ok | mci_w | low_ratio;                         // R4

	// Flag word in register bit order, bit 6 down to bit 0
	wire [6:0] flags_next = {mcm_w, pll_w, ser_w, auto_w, mci_w, bci_w, sri_w};

	////////////////////////////////////////////////////////////////////////////////
	// APB decode
	// Byte address carries the register index in bits 11 to 2; the low two bits are ignored
	wire [9:0] idx       = paddr[11:2];
	wire       setup     = psel & ~penable;
	wire       acc_wr    = psel & penable & pready & pwrite;
	wire       hit_stat  = idx == STAT_IDX;
	wire       hit_ctrl  = idx == CTRL_IDX;
	wire       hit_istat = idx == IRQ_STAT_IDX;
	wire       hit_imask = idx == IRQ_MASK_IDX;
	wire       mapped    = hit_stat | hit_ctrl | hit_istat | hit_imask;
	wire       wr_stat   = acc_wr & hit_stat & ~pslverr;
	wire       wr_ctrl   = acc_wr & hit_ctrl & ~pslverr;
	wire       wr_istat  = acc_wr & hit_istat & ~pslverr;
	wire       wr_imask  = acc_wr & hit_imask & ~pslverr;

	////////////////////////////////////////////////////////////////////////////////
	// Status, interrupt and control state
	logic [6:0] flags_reg;
	logic       stat_rsv_reg;
	logic [6:0] istat_reg, imask_reg;
	logic       irq_reg;

	wire [6:0]  ev          = flags_next & ~flags_reg;
	wire [6:0]  istat_next  = (istat_reg & ~({7{wr_istat}} & pwdata[6:0])) | ev;
	// The interrupt also uses the next mask, so it never lags a mask write by a cycle
	wire [6:0]  imask_next  = wr_imask ? pwdata[6:0] : imask_reg;
	wire [7:0]  stat_view   = {stat_rsv_reg, flags_reg};
	wire [31:0] rd_data     = hit_stat  ? {24'h000000, stat_view} :
	                          hit_ctrl  ? {30'h00000000, ctrl_reg} :
	                          hit_istat ? {25'h0000000, istat_reg} :
	                          hit_imask ? {25'h0000000, imask_reg} : 32'h00000000;

	// Flags are live copies of the detectors; writes never reach them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags_reg <= FLAGS_RESET;
		else
			flags_reg <= flags_next;                                    // R10
	end

	// Only the reserved top bit of the status register holds a written value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_rsv_reg <= 1'b0;
		else if (wr_stat)
			stat_rsv_reg <= pwdata[FL_RSV];                             // R10
	end

	// Control and mask registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg  <= CTRL_RESET;
			imask_reg <= MASK_RESET;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= pwdata[1:0];
			imask_reg <= imask_next;
		end
	end

	// Sticky events: a new event wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			istat_reg <= 7'h00;
			irq_reg   <= 1'b0;
		end
		else
		begin
			istat_reg <= istat_next;
			irq_reg   <= |(istat_next & imask_next);
		end
	end

	// APB answer is registered in setup, so every access has one wait-free access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? rd_data : 32'h00000000;
		end
	end

	assign pll_enable = ctrl_pll_en;
	assign irq        = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_mclk_missing_flag: assert property (mclk_rise |-> ##2 !flags_reg[FL_MCM]) // R1
		else $error("master clock missing flag set after an edge");
	a_pll_disabled_flag: assert property (!ctrl_pll_en ##1 !ctrl_pll_en |-> flags_reg[FL_PLL]) // R2
		else $error("pll disabled but not reported unlocked");
	a_serial_missing_low: assert property (flags_reg[FL_SER] |-> $past(!sclk_s && !lrclk_s)) // R3
		else $error("serial clocks missing reported while a clock was high");
	a_autoset_follows_mci: assert property (flags_reg[FL_MCI] |-> flags_reg[FL_AUTO]) // R4
		else $error("master clock invalid without auto set error");
	a_mclk_invalid_miss: assert property (mclk_miss |=> flags_reg[FL_MCI]) // R5
		else $error("missing master clock not flagged invalid");
	a_short_low_period: assert property (frame_ok && low_lat_reg <= 9'h005 |=> flags_reg[FL_MCI]) // R6
		else $error("short frame low period not flagged");
	a_bclk_out_range: assert property (sclk_lat_reg > 9'h100 || sclk_lat_reg < 9'h020 |=> flags_reg[FL_BCI]) // R7
		else $error("bit clock ratio out of range not flagged");
	a_rate_invalid_flag: assert property (!frame_ok && !ctrl_ignore |=> flags_reg[FL_SRI]) // R8
		else $error("no frame but rate reported valid");
	a_rate_ignore_clear: assert property (ctrl_ignore |=> !flags_reg[FL_SRI]) // R9
		else $error("rate invalid reported while ignored");
	a_status_rsv_write: assert property (wr_stat |=> stat_rsv_reg == $past(pwdata[FL_RSV]) && flags_reg == $past(flags_next)) // R10
		else $error("status write misbehaved");
	a_irq_level_out: assert property (|(istat_reg & imask_reg) |-> irq)
		else $error("interrupt low while unmasked event pending");
	a_serial_present_clear: assert property (sclk_rise |=> !flags_reg[FL_SER]) // R3
		else $error("serial clocks missing reported while bit clock toggles");
	a_pll_locked_clear: assert property (ctrl_pll_en && lock_s |=> !flags_reg[FL_PLL]) // R2
		else $error("pll enabled and locked but reported unlocked");

	// Bus handshake, interrupt output and pll enable
	a_irq_pending_only: assert property (irq |-> |(istat_reg & imask_reg))
		else $error("interrupt high with no unmasked event pending");
	a_pready_after_setup: assert property (setup |=> pready)
		else $error("no ready after a setup cycle");
	a_pready_only_access: assert property (!setup |=> !pready)
		else $error("ready without a preceding setup cycle");
	a_unmapped_error: assert property (setup && !mapped |=> pslverr)
		else $error("unmapped access not answered with an error");
	a_idle_read_zero: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data not zero outside an access cycle");
	a_pll_enable_write: assert property (wr_ctrl |=> pll_enable == $past(pwdata[CTRL_PLL_EN]))
		else $error("pll enable does not follow the control write");

	// Covers of the main scenarios
	c_frame_locked:  cover property (frame_ok && !flags_reg[FL_BCI] && !flags_reg[FL_SRI]);
	c_rate_ignored:  cover property (ctrl_ignore && !frame_ok);
	c_serial_lost:   cover property ($rose(flags_reg[FL_SER]));
	c_mclk_restored: cover property ($fell(flags_reg[FL_MCM]));
	c_irq_raised:    cover property ($rose(irq));
endmodule // acds_top
`default_nettype wire

// ==== verilog/acds_watchdog.sv ====
// Activity watchdog: reports missing once no kick arrived for LIMIT cycles
`default_nettype none
module acds_watchdog
	import acds_pkg::*;
#(
	parameter int LIMIT = MISS_CYC // Cycles without activity before missing
)
(
	input  wire logic pclk,    // System clock
	input  wire logic presetn, // Asynchronous reset, active low
	input  wire logic kick,    // Activity pulse
	output logic      missing  // High while no activity seen
);
	localparam int W = $clog2(LIMIT + 1);

	// Elaboration check: a limit below two leaves no room between kick and missing
	if (LIMIT < 2)
	begin : g_bad_limit
		$error("acds_watchdog: LIMIT must be at least 2");
	end

	logic [W-1:0] cnt_reg;
	logic         miss_reg;

	// Missing is assumed at reset until activity proves otherwise
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg  <= '0;
			miss_reg <= 1'b1;
		end
		else if (kick)
		begin
			cnt_reg  <= '0;
			miss_reg <= 1'b0;
		end
		else if (cnt_reg == W'(LIMIT))
			miss_reg <= 1'b1;
		else
			cnt_reg <= cnt_reg + W'(1);
	end

	assign missing = miss_reg;
endmodule // acds_watchdog
`default_nettype wire
